// file: shared/lpp_pkg.sv
// Constants, register map and pin carriers for the printer-style I/O port block.
// Assumes a single 100 MHz clock and an APB master with 32-bit data.
package lpp_pkg;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam logic [31:0] STEP_NS = 32'(CLK_PERIOD_NS);

  // ****************************************************************
  // Pin groups and view layout
  // ****************************************************************
  localparam int DATA_W = 8;
  localparam int CTRL_W = 4;
  localparam int STAT_W = 5;
  localparam int OUT_W = DATA_W + CTRL_W;
  localparam int IN_W = DATA_W + CTRL_W + STAT_W;
  localparam int MAX_PORTS = 8;
  localparam logic [15:0] INDEX_LIMIT = 16'h0010;

  // ****************************************************************
  // Register map (byte addresses)
  // ****************************************************************
  localparam int ADDR_W = 12;
  localparam logic [ADDR_W-1:0] CMD_ADDR = 12'h000;
  localparam logic [ADDR_W-1:0] STAT_ADDR = 12'h004;
  localparam logic [3:0] PORT_PAGE = 4'h1;
  localparam logic [2:0] REG_CFG = 3'h0;
  localparam logic [2:0] REG_ADDR = 3'h1;
  localparam logic [2:0] REG_OUT = 3'h2;
  localparam logic [2:0] REG_INV = 3'h3;
  localparam logic [2:0] REG_CLRSEL = 3'h4;
  localparam logic [2:0] REG_RTIME = 3'h5;
  localparam logic [2:0] REG_IN = 3'h6;
  localparam logic [2:0] REG_INNOT = 3'h7;

  // Field positions.
  localparam int CFG_LOCK_BIT = 8;
  localparam int CMD_ALL_BIT = 4;
  localparam int CMD_PORT_LSB = 8;
  localparam int ADDR_ISINDEX_BIT = 16;

  typedef enum logic [1:0] {
    LPP_MODE_OUT = 2'b00,
    LPP_MODE_IN = 2'b01,
    LPP_MODE_OC = 2'b10
  } lpp_mode_e;

  typedef enum logic [1:0] {
    LPP_OP_NONE = 2'b00,
    LPP_OP_READ = 2'b01,
    LPP_OP_WRITE = 2'b10,
    LPP_OP_CLEAR = 2'b11
  } lpp_op_e;

  typedef struct packed {
    logic [STAT_W-1:0] status;
    logic [CTRL_W-1:0] ctrl;
    logic [DATA_W-1:0] data;
  } lpp_pins_in_s;

  typedef struct packed {
    logic [CTRL_W-1:0] ctrlOut;
    logic [CTRL_W-1:0] ctrlOe;
    logic [DATA_W-1:0] dataOut;
    logic [DATA_W-1:0] dataOe;
  } lpp_pins_out_s;

endpackage

// file: hw/lpp_port_io.sv
// Printer-style general purpose I/O ports: data, control and status pin groups,
// reached over APB; host commands sample inputs, drive outputs and auto-clear them.
// Assumes pins are asynchronous to clk and control pins carry external pull-ups.
//
// Summary of operation
// R1: Seventeen pins: eight data, four control, five status.
// R2: Output mode gives twelve outputs, five inputs.
// R3: Input mode gives four outputs, thirteen inputs.
// R4: Open-drain mode adds control inputs: eight/nine.
// R5: Control pins always output, also input open-drain.
// R6: Undriven open-drain control pin reads true.
// R7: External control drivers must be open-drain.
// R8: Data direction locked once configured; here only a CFG write with CFG_LOCK_BIT set locks it.
// R9: Up to eight ports numbered from zero.
// R10: Mode selects data direction and control inputs.
// R11: Unconfigured data group defaults to output.
// R12: Address value below sixteen is port index.
// R13: At least one port address must be configured.
// R14: Inputs shown as true and complemented views.
// R15: Per-pin polarity chooses active-high or active-low.
// R16: Read samples pins of one or all ports.
// R17: Write drives outputs of one or all ports.
// R18: Clear waits programmed nanoseconds after write.
// R19: Clear returns selected pins to polarity value.
// R20: Controller issues clear after its write.
// R21: One step per period needs zero gap.
// R22: Avoid mixing all-port and single-port operations.
// R23: Inputs registered on read, outputs held.
//
// Added by the designer: the register addresses and register access over APB.
`timescale 1ns/1ns
module lpp_port_io #(
  parameter int NPORTS = lpp_pkg::MAX_PORTS
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [lpp_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Port pins
  input wire lpp_pkg::lpp_pins_in_s [NPORTS-1:0] pinsIn,
  output lpp_pkg::lpp_pins_out_s [NPORTS-1:0] pinsOut
);
  import lpp_pkg::*;

  // R9 up to eight ports
  if (NPORTS < 1 || NPORTS > MAX_PORTS) begin : gBadPorts
    $error("NPORTS must lie between 1 and 8.");
  end

  // ****************************************************************
  // Reset release and pin synchronisers
  // ****************************************************************
  logic rstMeta;
  logic rstSync;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rstMeta <= 1'b0;
      rstSync <= 1'b0;
    end else begin
      rstMeta <= 1'b1;
      rstSync <= rstMeta;
    end
  end
  wire logic rstN = rstSync;

  lpp_pins_in_s [NPORTS-1:0] pinMeta;
  lpp_pins_in_s [NPORTS-1:0] pinSync;
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      pinMeta <= '0;
      pinSync <= '0;
    end else begin
      pinMeta <= pinsIn;
      pinSync <= pinMeta;
    end
  end

  // ****************************************************************
  // APB decode
  // ****************************************************************
  logic accessWr;
  logic setupPhase;
  logic [2:0] regIdx;
  logic [2:0] portIdx;
  logic portHit;
  logic mapped;
  logic cmdWrite;
  lpp_op_e cmdOp;
  logic cmdAll;
  logic [2:0] cmdPort;

  assign accessWr = psel && penable && pwrite;
  assign setupPhase = psel && !penable;
  assign regIdx = paddr[4:2];
  assign portIdx = paddr[7:5];
  assign portHit = (paddr[11:8] == PORT_PAGE) && (32'(portIdx) < NPORTS)
    && (paddr[1:0] == 2'b00);
  assign mapped = (paddr == CMD_ADDR) || (paddr == STAT_ADDR) || portHit;
  assign cmdWrite = accessWr && (paddr == CMD_ADDR);
  assign cmdOp = lpp_op_e'(pwdata[1:0]);
  assign cmdAll = pwdata[CMD_ALL_BIT];
  assign cmdPort = pwdata[CMD_PORT_LSB +: 3];

  // The slave answers in the first access cycle, so pready is tied high.
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;

  logic [NPORTS-1:0][7:0][31:0] rdArr;
  logic [NPORTS-1:0] pending;
  logic [NPORTS-1:0] lockedAll;

  // ****************************************************************
  // Per-port logic
  // ****************************************************************
  genvar p;
  generate
    for (p = 0; p < NPORTS; p++) begin : gPort
      lpp_mode_e mode;
      lpp_mode_e next_mode;
      logic locked;
      logic next_locked;
      logic [15:0] addrVal;
      logic [15:0] next_addrVal;
      logic [OUT_W-1:0] outVal;
      logic [OUT_W-1:0] next_outVal;
      logic [OUT_W-1:0] invert;
      logic [OUT_W-1:0] next_invert;
      logic [OUT_W-1:0] clrSel;
      logic [OUT_W-1:0] next_clrSel;
      logic [31:0] resetTime;
      logic [31:0] next_resetTime;
      logic [OUT_W-1:0] pinLatch;
      logic [OUT_W-1:0] next_pinLatch;
      logic [IN_W-1:0] inTrue;
      logic [IN_W-1:0] next_inTrue;
      logic [31:0] elapsed;
      logic [31:0] next_elapsed;
      logic clrPend;
      logic next_clrPend;
      logic [IN_W-1:0] inMask;
      logic regWr;
      logic mine;
      logic doRead;
      logic doWrite;
      logic doClear;
      logic clrDue;

      assign regWr = accessWr && portHit && (32'(portIdx) == p);
      assign mine = cmdWrite && (cmdAll || (32'(cmdPort) == p));
      assign doRead = mine && (cmdOp == LPP_OP_READ);
      assign doWrite = mine && (cmdOp == LPP_OP_WRITE);
      assign doClear = mine && (cmdOp == LPP_OP_CLEAR);
      // R18 wait programmed delay
      assign clrDue = clrPend && (elapsed >= resetTime);

      // R10 mode selects input views
      // R1 R2 R3 R4 pin counts per mode
      assign inMask = {{STAT_W{1'b1}}, {CTRL_W{mode == LPP_MODE_OC}},
        {DATA_W{mode == LPP_MODE_IN}}};

      always_comb begin
        next_mode = mode;
        next_locked = locked;
        next_addrVal = addrVal;
        next_outVal = outVal;
        next_invert = invert;
        next_clrSel = clrSel;
        next_resetTime = resetTime;
        next_pinLatch = pinLatch;
        next_inTrue = inTrue;
        next_elapsed = elapsed;
        next_clrPend = clrPend;
        if (regWr) begin
          if (regIdx == REG_CFG) begin
            // R8 direction fixed once locked
            if (!locked) begin
              next_mode = (pwdata[1:0] == LPP_MODE_IN) ? LPP_MODE_IN :
                (pwdata[1:0] == LPP_MODE_OC) ? LPP_MODE_OC : LPP_MODE_OUT;
              next_locked = pwdata[CFG_LOCK_BIT];
            end
          end else if (regIdx == REG_ADDR) begin
            next_addrVal = pwdata[15:0];
          end else if (regIdx == REG_OUT) begin
            next_outVal = pwdata[OUT_W-1:0];
          end else if (regIdx == REG_INV) begin
            next_invert = pwdata[OUT_W-1:0];
          end else if (regIdx == REG_CLRSEL) begin
            next_clrSel = pwdata[OUT_W-1:0];
          end else if (regIdx == REG_RTIME) begin
            next_resetTime = pwdata;
          end
        end
        // The elapsed count stops at the target so it can never wrap.
        if (elapsed < resetTime) begin
          if (resetTime - elapsed > STEP_NS) begin
            next_elapsed = elapsed + STEP_NS;
          end else begin
            next_elapsed = resetTime;
          end
        end
        if (clrDue) begin
          // R19 selected pins to polarity
          next_pinLatch = (pinLatch & ~clrSel) | (invert & clrSel);
          next_clrPend = 1'b0;
        end
        if (doWrite) begin
          // R17 write drives outputs
          // R15 polarity per pin
          next_pinLatch = outVal ^ invert;
          next_elapsed = '0;
        end
        // R20 clear follows write
        if (doClear) begin
          next_clrPend = 1'b1;
        end
        if (doRead) begin
          // R16 sample inputs on read
          next_inTrue = pinSync[p] & inMask;
        end
      end

      // R23 outputs held between operations
      always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
          // R11 default output mode
          mode <= LPP_MODE_OUT;
          locked <= 1'b0;
          addrVal <= '0;
          outVal <= '0;
          invert <= '0;
          clrSel <= '0;
          resetTime <= '0;
          pinLatch <= '0;
          inTrue <= '0;
          elapsed <= '0;
          clrPend <= 1'b0;
        end else begin
          mode <= next_mode;
          locked <= next_locked;
          addrVal <= next_addrVal;
          outVal <= next_outVal;
          invert <= next_invert;
          clrSel <= next_clrSel;
          resetTime <= next_resetTime;
          pinLatch <= next_pinLatch;
          inTrue <= next_inTrue;
          elapsed <= next_elapsed;
          clrPend <= next_clrPend;
        end
      end

      // R5 control driven in output and input modes, open-drain in OC mode
      // R6 open-drain releases high
      assign pinsOut[p].dataOut = pinLatch[DATA_W-1:0];
      assign pinsOut[p].dataOe = {DATA_W{mode != LPP_MODE_IN}};
      assign pinsOut[p].ctrlOut = (mode == LPP_MODE_OC) ? '0 : pinLatch[OUT_W-1:DATA_W];
      assign pinsOut[p].ctrlOe = (mode == LPP_MODE_OC) ? ~pinLatch[OUT_W-1:DATA_W] :
        {CTRL_W{1'b1}};

      assign pending[p] = clrPend;
      assign lockedAll[p] = locked;
      assign rdArr[p][REG_CFG] = 32'({locked, 6'h00, mode});
      // R12 small value is index
      assign rdArr[p][REG_ADDR] = 32'({addrVal < INDEX_LIMIT, addrVal});
      assign rdArr[p][REG_OUT] = 32'(outVal);
      assign rdArr[p][REG_INV] = 32'(invert);
      assign rdArr[p][REG_CLRSEL] = 32'(clrSel);
      assign rdArr[p][REG_RTIME] = resetTime;
      // R14 true and complemented views
      assign rdArr[p][REG_IN] = 32'(inTrue);
      assign rdArr[p][REG_INNOT] = 32'(~inTrue & inMask);
    end
  endgenerate

  // ****************************************************************
  // Read data, captured in the setup cycle
  // ****************************************************************
  logic [31:0] next_prdata;
  always_comb begin
    next_prdata = prdata;
    if (setupPhase) begin
      if (paddr == STAT_ADDR) begin
        next_prdata = {16'h0000, 8'(lockedAll), 8'(pending)};
      end else if (portHit) begin
        next_prdata = rdArr[portIdx][regIdx];
      end else begin
        next_prdata = '0;
      end
    end
  end

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      prdata <= '0;
    end else begin
      prdata <= next_prdata;
    end
  end

endmodule

// file: verification/lpp_port_io_sva.sv
// Concurrent checks on the APB side, the port 0 pins and the hold of all port pins of the I/O port block.
// Sees only the top-level ports; bound into every instance of the block.
`timescale 1ns/1ns
module lpp_port_io_sva #(
  parameter int NPORTS = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [lpp_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Pins
  input wire lpp_pkg::lpp_pins_in_s [NPORTS-1:0] pinsIn,
  input wire lpp_pkg::lpp_pins_out_s [NPORTS-1:0] pinsOut
);
  import lpp_pkg::*;
  logic clrSeen;
  logic next_clrSeen;
  logic mapped;
  logic acc;
  assign acc = psel && penable;
  assign mapped = paddr == CMD_ADDR || paddr == STAT_ADDR || (paddr[11:8] == PORT_PAGE
    && int'(paddr[7:5]) < NPORTS && paddr[1:0] == 2'b00);
  // Once a clear was issued, pins may move on their own, so the hold check stops.
  always_comb begin
    next_clrSeen = clrSeen;
    if (acc && pwrite && paddr == CMD_ADDR && pwdata[1:0] == LPP_OP_CLEAR) begin
      next_clrSeen = 1'b1;
    end
  end
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      clrSeen <= 1'b0;
    end else begin
      clrSeen <= next_clrSeen;
    end
  end
  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  AST_RDY: assert property (acc |-> pready) else $error("ready low in access");
  AST_MAP: assert property (acc |-> pslverr == !mapped)
    else $error("slave error flag wrong");
  AST_RDZ: assert property (acc && !pwrite && !mapped |-> prdata == 32'h0)
    else $error("unmapped read not zero");
  AST_STAB: assert property (acc |=> $stable(prdata))
    else $error("read data moved in access");
  AST_DEFOUT: assert property ($rose(nrst) |=> (pinsOut[0].dataOe == 8'hFF) [*2])
    else $error("data not output after reset");
  AST_DATDIR: assert property (pinsOut[0].dataOe inside {8'h00, 8'hFF})
    else $error("data direction split");
  AST_ODMODE: assert property (pinsOut[0].ctrlOe != 4'hF |-> pinsOut[0].dataOe == 8'hFF)
    else $error("open-drain mode lost data outputs");
  AST_ODLOW: assert property (pinsOut[0].ctrlOe != 4'hF |->
    (pinsOut[0].ctrlOut & pinsOut[0].ctrlOe) == 4'h0) else $error("control driven high");
  AST_HOLD: assert property (!clrSeen && $changed(pinsOut) |-> $past(acc && pwrite))
    else $error("pins moved without a write");
endmodule
bind lpp_port_io lpp_port_io_sva #(.NPORTS(NPORTS)) i_lpp_port_io_sva (.clk(clk), .nrst(nrst),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .pinsIn(pinsIn), .pinsOut(pinsOut));

// file: verification/lpp_pin_model.sv
// Machine side of the port: switches on data and status, open-drain pull-downs on control.
// Assumes control lines carry pull-ups, so a released line reads high.
`timescale 1ns/1ns
module lpp_pin_model #(
  parameter int N = 2
) (
  // Device side
  input wire lpp_pkg::lpp_pins_out_s [N-1:0] pinsOut,
  // Machine side
  input wire logic [7:0] extData,
  input wire logic [3:0] extPull,
  input wire logic [4:0] extStat,
  output lpp_pkg::lpp_pins_in_s [N-1:0] pinsIn
);
  import lpp_pkg::*;
  always_comb begin
    for (int p = 0; p < N; p++) begin
      pinsIn[p].status = extStat;
      pinsIn[p].ctrl = (pinsOut[p].ctrlOut | ~pinsOut[p].ctrlOe) & ~extPull;
      pinsIn[p].data = (pinsOut[p].dataOe & pinsOut[p].dataOut) | (~pinsOut[p].dataOe & extData);
    end
  end
endmodule

// file: verification/legacy_printer_port_io_bench.sv
// Self-checking bench for the printer-style I/O port block with two ports.
// Assumes the pin model on the far side and the bound checker.
`timescale 1ns/1ns
module legacy_printer_port_io_bench;
  import lpp_pkg::*;
  localparam int NP = 2;
  logic clk, nrst, psel, penable, pwrite, pready, pslverr, err;
  logic [ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata, seed, r, o, v;
  logic [7:0] extData;
  logic [3:0] extPull;
  logic [4:0] extStat;
  logic [2:0] p;
  lpp_pins_in_s [NP-1:0] pinsIn;
  lpp_pins_out_s [NP-1:0] pinsOut;
  int fails, totalChecks, n;
`define CHK(a, b) begin totalChecks++; if ((a) !== (b)) begin fails++; \
  $display("[ERR] t=%0t got %h exp %h", $time, a, b); end end
  lpp_port_io #(.NPORTS(NP)) i_lpp_port_io (.clk(clk), .nrst(nrst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pinsIn(pinsIn), .pinsOut(pinsOut));
  lpp_pin_model #(.N(NP)) i_lpp_pin_model (.pinsOut(pinsOut), .extData(extData),
    .extPull(extPull), .extStat(extStat), .pinsIn(pinsIn));
  function logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function logic [11:0] pa(int q, logic [2:0] k);
    return {PORT_PAGE, 3'(q), k, 2'b00};
  endfunction
  function logic [31:0] cmd(logic [1:0] op, logic all, logic [2:0] q);
    return {21'h0, q, 3'h0, all, 2'h0, op};
  endfunction
  function logic [31:0] view(logic [16:0] x, logic cm, logic dm);
    return {15'h0, x[16:12], x[11:8] & {4{cm}}, x[7:0] & {8{dm}}};
  endfunction
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin @(posedge clk); n++; end while (pready !== 1'b1);
    r = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic pins(input logic [31:0] x);
    @(posedge clk);
    extData <= x[7:0]; extPull <= x[11:8]; extStat <= x[16:12];
    repeat (3) @(posedge clk);
  endtask
  task automatic views(input logic [2:0] q, input logic [16:0] x, input logic cm, dm);
    xfer(1'b1, CMD_ADDR, cmd(LPP_OP_READ, 1'b0, q));
    xfer(1'b0, pa(q, REG_IN), 32'h0);
    `CHK(r, view(x, cm, dm))
    xfer(1'b0, pa(q, REG_INNOT), 32'h0);
    `CHK(r, view(~x, cm, dm))
  endtask
  task complete_run();
    $display("checks %0d mismatches %0d", totalChecks, fails);
    if (fails == 0 && totalChecks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    repeat (5000) @(posedge clk);
    fails++;
    complete_run();
  end
  initial begin
    nrst = 0; psel = 0; penable = 0; pwrite = 0; paddr = '0; pwdata = '0; seed = 32'h4C;
    extData = 8'h00; extPull = 4'h0; extStat = 5'h00;
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    repeat (3) @(posedge clk);
    `CHK(pinsOut[1].dataOe, 8'hFF)
    `CHK(pinsOut[1].ctrlOe, 4'hF)
    xfer(1'b0, STAT_ADDR, 32'h0);
    `CHK(r, 32'h0)
    $display("test reset done");
    for (int i = 0; i < 4; i++) begin
      p = 3'(i % 2); o = rnd(); v = rnd();
      xfer(1'b1, pa(p, REG_OUT), o);
      xfer(1'b1, pa(p, REG_INV), v);
      xfer(1'b1, CMD_ADDR, cmd(LPP_OP_WRITE, i >= 2, p));
      @(negedge clk);
      `CHK(pinsOut[p].dataOut, o[7:0] ^ v[7:0])
      `CHK(pinsOut[p].ctrlOut, o[11:8] ^ v[11:8])
    end
    $display("test write done");
    xfer(1'b1, pa(1, REG_CFG), 32'h003);
    @(negedge clk);
    `CHK(pinsOut[1].dataOe, 8'hFF)
    xfer(1'b1, pa(1, REG_CFG), 32'h101);
    @(negedge clk);
    `CHK(pinsOut[1].dataOe, 8'h00)
    v = rnd() & 32'h1F0FF;
    pins(v);
    views(3'h1, v[16:0], 1'b0, 1'b1);
    xfer(1'b1, pa(1, REG_CFG), 32'h0);
    @(negedge clk);
    `CHK(pinsOut[1].dataOe, 8'h00)
    xfer(1'b0, STAT_ADDR, 32'h0);
    `CHK(r[15:8], 8'h02)
    $display("test input done");
    xfer(1'b1, pa(0, REG_CFG), 32'h102);
    xfer(1'b1, pa(0, REG_INV), 32'h0);
    xfer(1'b1, pa(0, REG_OUT), 32'hC00);
    xfer(1'b1, CMD_ADDR, cmd(LPP_OP_WRITE, 1'b0, 3'h0));
    @(negedge clk);
    `CHK(pinsOut[0].ctrlOe, 4'h3)
    `CHK(pinsOut[0].dataOe, 8'hFF)
    v = (rnd() & 32'h1F0FF) | 32'h400;
    pins(v);
    views(3'h0, {v[16:12], 4'h8, v[7:0]}, 1'b1, 1'b0);
    $display("test open-drain done");
    xfer(1'b1, pa(0, REG_RTIME), 32'h50);
    xfer(1'b1, pa(0, REG_CLRSEL), 32'h00F);
    xfer(1'b1, pa(0, REG_INV), 32'h00C);
    xfer(1'b1, pa(0, REG_OUT), 32'h0FF);
    xfer(1'b1, CMD_ADDR, cmd(LPP_OP_WRITE, 1'b0, 3'h0));
    xfer(1'b1, CMD_ADDR, cmd(LPP_OP_CLEAR, 1'b0, 3'h0));
    xfer(1'b0, STAT_ADDR, 32'h0);
    `CHK(r[0], 1'b1)
    @(negedge clk);
    `CHK(pinsOut[0].dataOut, 8'hF3)
    n = 0;
    while (pinsOut[0].dataOut !== 8'hFC && n < 10) begin @(posedge clk); n++; end
    `CHK(pinsOut[0].dataOut, 8'hFC)
    xfer(1'b0, STAT_ADDR, 32'h0);
    `CHK(r[0], 1'b0)
    xfer(1'b1, CMD_ADDR, cmd(LPP_OP_NONE, 1'b1, 3'h0));
    @(negedge clk);
    `CHK(pinsOut[0].dataOut, 8'hFC)
    $display("test clear done");
    for (int k = 15; k < 17; k++) begin
      xfer(1'b1, pa(0, REG_ADDR), 32'(k));
      xfer(1'b0, pa(0, REG_ADDR), 32'h0);
      `CHK(r[16], 1'(k < 16))
    end
    xfer(1'b0, 12'h008, 32'h0);
    `CHK({err, r}, {1'b1, 32'h0})
    xfer(1'b0, pa(2, REG_CFG), 32'h0);
    `CHK(err, 1'b1)
    xfer(1'b0, CMD_ADDR, 32'h0);
    `CHK({err, r}, {1'b0, 32'h0})
    $display("test map done");
    complete_run();
  end
endmodule
